// File: bac_top.sv
/*
 * Burst address counter of one RAM port: counter, mask and mirror registers,
 * load, increment, hold, clear and readback over the shared address lines,
 * and the active-low wrap flag.
 * Assumes controls synchronous to clk and an external pad resolving
 * addrOut/addrOe/addrIn into the bidirectional address lines.
 */
// Function
// - Hold keeps counter, mask and mirror unchanged for any number of cycles.
// - Wrap flag goes low when an increment leaves all unmasked bits at one.
// - Wrap flag goes high when an increment gives any other unmasked value.
// - Counter clear, counter load, mask set, mask load, master reset release the flag.
// - Counter readback drives the counter on the address lines after the next edge.
// - Mask readback drives the mask on the address lines after the next edge.
// - Readback with chip selected floats the data lines.
// - Master reset low clears counter to zeros and sets mask to ones.
// - Counter clear zeroes unmasked counter bits and keeps masked bits.
// - Select high, clear high, strobe low, step low loads the counter.
// - Select high, clear high, strobe low, step high reads back the counter.
// - Select high, clear high, strobe high, step low increments the counter.
// - Select high, clear high, strobe high, step high holds the counter.
// - Select low with clear low sets every mask bit to one.
// - Select low, clear high, strobe low, step low loads the mask.
// - Select low, clear high, strobe low, step high reads back the mask.
// - Counter and mask operations ignore the chip selects.
// - Increment at the unmasked maximum reloads the counter from the mirror.
// - Mask bit zero clear makes each increment step by two.
// - Increment changes only counter bits whose mask bit is one.
// - Counter load writes the address into both counter and mirror.
// - Counter clear copies the cleared counter into the mirror.
// - Master reset is asynchronous; other controls are sampled on clk.
`include "bac_consts.svh"

module bac_top #(
    parameter int AW = `BAC_ADDR_W
) (
    // Clock and resets
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               globalInitN,
    // Counter and mask controls
    input  wire bac_pkg::bac_ctrl_t ctrl,
    // Chip selects of the port
    input  wire logic               chipSelectLow,
    input  wire logic               chipSelectHigh,
    // Shared address lines
    input  wire logic [AW-1:0]      addrIn,
    output logic      [AW-1:0]      addrOut,
    output logic                    addrOe,
    // Address toward the array, data float request, wrap flag
    output logic      [AW-1:0]      ramAddr,
    output logic                    dqHighZ,
    output logic                    wrapFlagN
);
    import bac_pkg::*;

    localparam logic [AW-1:0] CNT_RST  = {AW{`BAC_CNT_FILL}};
    localparam logic [AW-1:0] MASK_ALL = {AW{`BAC_MASK_FILL}};

    bac_op_t       op;
    logic [AW-1:0] counter;
    logic [AW-1:0] mask;
    logic [AW-1:0] mirror;
    logic [AW-1:0] nextInc;
    logic          atMax;
    logic          nextAtMax;

    wire           initRst;
    wire           chipSelected;
    wire           isInc;
    wire           isCntLoad;
    wire           isCntClear;
    wire           isCntRead;
    wire           isMaskRead;
    wire           isReadback;
    wire           releasesFlag;
    wire [AW-1:0]  clearedCnt;
    wire [AW-1:0]  next_counter;
    wire [AW-1:0]  next_mirror;
    wire [AW-1:0]  next_mask;
    wire [AW-1:0]  next_addrOut;
    wire           next_addrOe;
    wire           next_dqHighZ;
    wire           next_wrapFlagN;

    bac_op_decode u_decode (
        .ctrl (ctrl),
        .op   (op)
    );

    bac_count_step #(
        .AW (AW)
    ) u_step (
        .counter   (counter),
        .mask      (mask),
        .mirror    (mirror),
        .nextInc   (nextInc),
        .atMax     (atMax),
        .nextAtMax (nextAtMax)
    );

    // Either reset source clears the registers at once
    assign initRst = sys_rst | ~globalInitN;

    // Port enabled: first select low, second high
    assign chipSelected = !chipSelectLow && chipSelectHigh;

    assign isInc        = (op == OP_INC);
    assign isCntLoad    = (op == OP_CNT_LOAD);
    assign isCntClear   = (op == OP_CNT_CLEAR);
    assign isCntRead    = (op == OP_CNT_READ);
    assign isMaskRead   = (op == OP_MASK_READ);
    assign isReadback   = isCntRead || isMaskRead;
    assign releasesFlag = isCntClear || isCntLoad ||
                          (op == OP_MASK_SET) || (op == OP_MASK_LOAD);

    assign clearedCnt = counter & ~mask;

    // Counter: clear, load, increment, otherwise hold
    assign next_counter = isCntClear ? clearedCnt :
                          isCntLoad  ? addrIn :
                          isInc      ? nextInc :
                                       counter;

    // Mirror follows every counter load and clear
    assign next_mirror = isCntClear ? clearedCnt :
                         isCntLoad  ? addrIn :
                                      mirror;

    assign next_mask = (op == OP_MASK_SET)  ? MASK_ALL :
                       (op == OP_MASK_LOAD) ? addrIn :
                                              mask;

    // Readback is registered, so it appears after the following edge
    assign next_addrOut = isCntRead  ? counter :
                          isMaskRead ? mask :
                                       addrOut;
    assign next_addrOe  = isReadback;

    // Chip selects only float the data lines; counting ignores them
    assign next_dqHighZ = isReadback && chipSelected;

    assign next_wrapFlagN = isInc ? (nextAtMax ? `BAC_FLAG_RAISED
                                               : `BAC_FLAG_IDLE) :
                            releasesFlag ? `BAC_FLAG_IDLE :
                                           wrapFlagN;

    always_ff @(posedge clk or posedge initRst) begin
        if (initRst) begin
            counter   <= CNT_RST;
            mask      <= MASK_ALL;
            mirror    <= CNT_RST;
            wrapFlagN <= `BAC_FLAG_IDLE;
        end else begin
            counter   <= next_counter;
            mask      <= next_mask;
            mirror    <= next_mirror;
            wrapFlagN <= next_wrapFlagN;
        end
    end

    always_ff @(posedge clk or posedge initRst) begin
        if (initRst) begin
            ramAddr <= CNT_RST;
            addrOut <= CNT_RST;
            addrOe  <= `BAC_OFF;
            dqHighZ <= `BAC_OFF;
        end else begin
            ramAddr <= next_counter;
            addrOut <= next_addrOut;
            addrOe  <= next_addrOe;
            dqHighZ <= next_dqHighZ;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (initRst);

    chk_hold_keeps_all: assert property (
        (op == OP_HOLD) |=> (counter == $past(counter)) && (mask == $past(mask))
                            && (mirror == $past(mirror)) && $stable(wrapFlagN))
        else $error("hold changed a register");

    chk_hold_long_run: assert property (
        (op == OP_HOLD) [*4] |=> (ramAddr == $past(ramAddr, 4)))
        else $error("counter moved during a run of holds");

    chk_wrap_flag_low: assert property (
        (isInc && nextAtMax) |=> (wrapFlagN == `BAC_FLAG_RAISED))
        else $error("wrap flag not raised at unmasked maximum");

    chk_wrap_flag_high: assert property (
        (isInc && !nextAtMax) |=> (wrapFlagN == `BAC_FLAG_IDLE))
        else $error("wrap flag not released by increment");

    chk_flag_release_ops: assert property (
        releasesFlag |=> (wrapFlagN == `BAC_FLAG_IDLE))
        else $error("wrap flag not released by load or reset");

    chk_cnt_readback: assert property (
        isCntRead |=> addrOe && (addrOut == $past(counter)))
        else $error("counter readback wrong");

    chk_cnt_read_code: assert property (
        (ctrl.counterOrMaskSelect && ctrl.counterClearN && !ctrl.addressStrobeN
         && ctrl.countStepN) |=> addrOe && $stable(counter))
        else $error("counter readback code not decoded");

    chk_mask_readback: assert property (
        isMaskRead |=> addrOe && (addrOut == $past(mask)))
        else $error("mask readback wrong");

    chk_mask_read_code: assert property (
        (!ctrl.counterOrMaskSelect && ctrl.counterClearN && !ctrl.addressStrobeN
         && ctrl.countStepN) |=> addrOe && $stable(mask))
        else $error("mask readback code not decoded");

    chk_data_float: assert property (
        (isReadback && chipSelected) |=> dqHighZ ##1 (dqHighZ == $past(isReadback
                                                      && chipSelected)))
        else $error("data lines not floated during readback");

    chk_drive_release: assert property (
        !isReadback |=> !addrOe)
        else $error("address lines driven outside readback");

    chk_cnt_clear: assert property (
        isCntClear |=> (counter == ($past(counter) & ~$past(mask)))
                       && (mirror == counter))
        else $error("counter clear wrong");

    chk_clear_mirror: assert property (
        isCntClear |=> (mirror == ($past(counter) & ~$past(mask))))
        else $error("mirror not taken from cleared counter");

    chk_cnt_load: assert property (
        isCntLoad |=> (counter == $past(addrIn)) && (ramAddr == counter))
        else $error("counter load wrong");

    chk_load_mirror: assert property (
        isCntLoad |=> (mirror == $past(addrIn)))
        else $error("mirror not loaded with counter");

    chk_inc_step: assert property (
        (isInc && !atMax && mask[0] && (mask != MASK_ALL))
        |=> ((counter & mask) == (($past(counter) & $past(mask)) + 1'b1)))
        else $error("increment did not advance by one");

    chk_mask_set: assert property (
        (op == OP_MASK_SET) |=> (mask == MASK_ALL) && $stable(counter))
        else $error("mask set wrong");

    chk_mask_load: assert property (
        (op == OP_MASK_LOAD) |=> (mask == $past(addrIn)) && $stable(mirror))
        else $error("mask load wrong");

    chk_select_ignored: assert property (
        (isInc && !chipSelected) |=> (counter == $past(nextInc)))
        else $error("increment blocked by chip select");

    chk_wrap_to_mirror: assert property (
        (isInc && atMax) |=> (counter == $past(mirror)))
        else $error("wrap did not reload from mirror");

    chk_step_by_two: assert property (
        (isInc && !atMax && !mask[0])
        |=> (counter[0] == $past(counter[0])) && (counter != $past(counter)))
        else $error("counting by two wrong");

    chk_masked_bits_kept: assert property (
        (isInc && !atMax) |=> ((counter & ~mask) == ($past(counter) & ~$past(mask))))
        else $error("masked counter bits changed");

    chk_reserved_idle: assert property (
        (op == OP_RESERVED) |=> $stable(counter) && $stable(mask)
                                && $stable(mirror) && $stable(wrapFlagN))
        else $error("reserved code changed state");

    chk_reset_values: assert property (
        $fell(initRst) |-> (counter == CNT_RST) && (mask == MASK_ALL)
                           && (mirror == CNT_RST) && (wrapFlagN == `BAC_FLAG_IDLE))
        else $error("register values after reset wrong");

    chk_ram_copy: assert property (
        ramAddr == counter)
        else $error("array address differs from counter");

    chk_float_needs_select: assert property (
        (isReadback && !chipSelected) |=> !dqHighZ)
        else $error("data lines floated while port not selected");

    chk_mask_kept_by_count: assert property (
        (isInc || isCntLoad || isCntClear) |=> $stable(mask))
        else $error("counter operation changed the mask");

    chk_hold_lines_free: assert property (
        (op == OP_HOLD) |=> !addrOe && !dqHighZ)
        else $error("hold drove the address lines");

endmodule // bac_top

// File: bac_consts.svh
/*
 * Named constants of the burst address counter: widths, reset fills,
 * increment steps and flag levels.
 * Assumes it is included by bare name, before the package and modules.
 */
`ifndef BAC_CONSTS_SVH
`define BAC_CONSTS_SVH

// Default port address width
`define BAC_ADDR_W      18

// Fill bits for the reset values of counter, mirror and mask
`define BAC_CNT_FILL    1'b0
`define BAC_MASK_FILL   1'b1

// Increment sizes with the lowest bit unmasked or masked
`define BAC_STEP_ONE    2'h1
`define BAC_STEP_TWO    2'h2

// Levels of the active-low wrap flag
`define BAC_FLAG_IDLE   1'b1
`define BAC_FLAG_RAISED 1'b0

// Levels of an inactive and an active drive enable or data float request
`define BAC_OFF         1'b0
`define BAC_ON          1'b1

`endif

// File: bac_pkg.sv
/*
 * Types shared by the burst address counter modules.
 * Assumes bac_consts.svh is available for the modules that use it.
 */
package bac_pkg;

    // Per-port counter and mask control inputs, sampled on clk
    typedef struct packed {
        logic counterOrMaskSelect;
        logic counterClearN;
        logic addressStrobeN;
        logic countStepN;
    } bac_ctrl_t;

    // Decoded operation of one clock edge
    typedef enum logic [3:0] {
        OP_CNT_CLEAR,
        OP_CNT_LOAD,
        OP_CNT_READ,
        OP_INC,
        OP_HOLD,
        OP_MASK_SET,
        OP_MASK_LOAD,
        OP_MASK_READ,
        OP_RESERVED
    } bac_op_t;

endpackage

// File: bac_op_decode.sv
/*
 * Decoder from the four counter and mask control inputs to one operation.
 * Assumes the controls are stable around the rising edge of the port clock.
 */
module bac_op_decode (
    // Control inputs
    input  bac_pkg::bac_ctrl_t ctrl,
    // Decoded operation
    output bac_pkg::bac_op_t   op
);
    import bac_pkg::*;

    wire       selCounter;
    wire       clearReq;
    wire       strobeLow;
    wire       stepLow;
    bac_op_t   counterOp;
    bac_op_t   maskOp;

    assign selCounter = ctrl.counterOrMaskSelect;
    assign clearReq   = !ctrl.counterClearN;
    assign strobeLow  = !ctrl.addressStrobeN;
    assign stepLow    = !ctrl.countStepN;

    // Counter side: clear wins, then strobe and step pick the rest
    assign counterOp = clearReq  ? OP_CNT_CLEAR :
                       strobeLow ? (stepLow ? OP_CNT_LOAD : OP_CNT_READ) :
                                   (stepLow ? OP_INC : OP_HOLD);

    // Mask side: strobe high is the undefined code
    assign maskOp = clearReq  ? OP_MASK_SET :
                    strobeLow ? (stepLow ? OP_MASK_LOAD : OP_MASK_READ) :
                                OP_RESERVED;

    assign op = selCounter ? counterOp : maskOp;

endmodule // bac_op_decode

// File: bac_count_step.sv
/*
 * Next counter value for an increment, with masked wrap to the mirror.
 * Assumes a mask of contiguous low ones, optionally with bit zero clear.
 */
`include "bac_consts.svh"

module bac_count_step #(
    parameter int AW = `BAC_ADDR_W
) (
    // Register values
    input  logic [AW-1:0] counter,
    input  logic [AW-1:0] mask,
    input  logic [AW-1:0] mirror,
    // Increment result and wrap detection
    output logic [AW-1:0] nextInc,
    output logic          atMax,
    output logic          nextAtMax
);
    import bac_pkg::*;

    // True when every unmasked bit of the value is one
    function automatic logic allOnes(input logic [AW-1:0] value,
                                     input logic [AW-1:0] m);
        return (value & m) == m;
    endfunction

    wire [AW-1:0] step;
    wire [AW-1:0] bumped;
    wire [AW-1:0] counted;

    assign step    = mask[0] ? AW'(`BAC_STEP_ONE) : AW'(`BAC_STEP_TWO);
    assign bumped  = (counter & mask) + step;
    assign counted = (bumped & mask) | (counter & ~mask);
    assign atMax   = allOnes(counter, mask);
    assign nextInc = atMax ? mirror : counted;
    assign nextAtMax = allOnes(nextInc, mask);

endmodule // bac_count_step

// File: bac_host_model.sv
/*
 * Host memory controller model that drives one port of the burst address counter.
 * Assumes the bench calls apply() just after a rising edge of clk. The model
 * works out the level of the shared address lines from its own drive and the
 * device's drive.
 */
module bac_host_model #(
    parameter int AW = 18
) (
    // Clock
    input  wire logic          clk,
    // Device side of the shared address lines
    input  wire logic [AW-1:0] addrOut,
    input  wire logic          addrOe,
    // Controls toward the device
    output bac_pkg::bac_ctrl_t ctrl,
    output logic               chipSelectLow,
    output logic               chipSelectHigh,
    output logic [AW-1:0]      addrIn
);
    import bac_pkg::*;

    logic          hostDrive;
    logic [AW-1:0] hostAddr;
    logic [AW-1:0] lastWire;

    initial begin
        ctrl           = bac_ctrl_t'(4'hf);
        chipSelectLow  = 1'b1;
        chipSelectHigh = 1'b0;
        hostDrive      = 1'b0;
        hostAddr       = '0;
        lastWire       = '0;
    end

    // Undriven lines flip every cycle, so a stale value is never mistaken for data
    assign addrIn = addrOe ? addrOut : (hostDrive ? hostAddr : ~lastWire);

    always @(posedge clk) begin
        lastWire <= addrIn;
    end

    // One control code for one edge; only the two load codes drive the lines
    task automatic apply(input logic [3:0] code, input logic [AW-1:0] a);
        // A load waits one held cycle while the device still drives a readback
        if ((code[2:0] == 3'b100) && addrOe) begin
            ctrl      = bac_ctrl_t'(4'hf);
            hostDrive = 1'b0;
            @(posedge clk);
            #1;
        end
        ctrl      = bac_ctrl_t'(code);
        hostAddr  = a;
        hostDrive = (code[2:0] == 3'b100);
        @(posedge clk);
        #1;
    endtask

    task automatic select(input logic low, input logic high);
        chipSelectLow  = low;
        chipSelectHigh = high;
    endtask
endmodule // bac_host_model

// File: test_bac_top.sv
/*
 * Self-checking bench for bac_top. The bench drives the host model through
 * the scenarios and then gives a verdict.
 * Assumes bac_pkg and bac_host_model are compiled first.
 */
module test_bac_top;
    timeunit 1ns;
    timeprecision 100ps;
    import bac_pkg::*;

    localparam int              AW        = 18;
    localparam logic [3:0]      CNT_CLEAR = 4'h8;
    localparam logic [3:0]      CNT_LOAD  = 4'hc;
    localparam logic [3:0]      CNT_READ  = 4'hd;
    localparam logic [3:0]      INC       = 4'he;
    localparam logic [3:0]      HOLD      = 4'hf;
    localparam logic [3:0]      MASK_SET  = 4'h0;
    localparam logic [3:0]      MASK_LOAD = 4'h4;
    localparam logic [3:0]      MASK_READ = 4'h5;
    localparam logic [AW-1:0]   ONES      = '1;

    logic          clk = 1'b0;
    logic          sys_rst;
    logic          globalInitN;
    bac_ctrl_t     ctrl;
    logic          chipSelectLow;
    logic          chipSelectHigh;
    logic [AW-1:0] addrIn;
    logic [AW-1:0] addrOut;
    logic          addrOe;
    logic [AW-1:0] ramAddr;
    logic          dqHighZ;
    logic          wrapFlagN;
    int            miscompares = 0;
    int            cmp_count = 0;

    always #5 clk = ~clk;

    bac_top #(.AW(AW)) u_bac_top (
        .clk(clk), .sys_rst(sys_rst), .globalInitN(globalInitN), .ctrl(ctrl),
        .chipSelectLow(chipSelectLow), .chipSelectHigh(chipSelectHigh),
        .addrIn(addrIn), .addrOut(addrOut), .addrOe(addrOe), .ramAddr(ramAddr),
        .dqHighZ(dqHighZ), .wrapFlagN(wrapFlagN)
    );

    bac_host_model #(.AW(AW)) u_bac_host_model (
        .clk(clk), .addrOut(addrOut), .addrOe(addrOe), .ctrl(ctrl),
        .chipSelectLow(chipSelectLow), .chipSelectHigh(chipSelectHigh), .addrIn(addrIn)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic op(input logic [3:0] code, input logic [AW-1:0] a = '0);
        u_bac_host_model.apply(code, a);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tReset();
        check("ramAddr", 32'(ramAddr), 32'h0);
        check("wrapFlagN", 32'(wrapFlagN), 32'h1);
        op(MASK_READ);
        check("addrOe", 32'(addrOe), 32'h1);
        check("mask", 32'(addrOut), 32'(ONES));
        check("dqHighZ", 32'(dqHighZ), 32'h0);
    endtask

    task automatic tWrap();
        op(MASK_LOAD, 18'h3f);
        op(CNT_LOAD, 18'h20008);
        check("loaded", 32'(ramAddr), 32'h20008);
        for (int p = 0; p < 2; p++) begin
            for (int i = 9; i <= 'h3f; i++) begin
                op(INC);
                check("count", 32'(ramAddr), 32'h20000 + 32'(i));
                check("wrapFlagN", 32'(wrapFlagN), (i == 'h3f) ? 32'h0 : 32'h1);
            end
            op(INC);
            check("rewind", 32'(ramAddr), 32'h20008);
            check("wrapFlagN", 32'(wrapFlagN), 32'h1);
        end
    endtask

    task automatic tHold();
        op(CNT_LOAD, 18'h2003e);
        op(INC);
        repeat (20) op(HOLD);
        check("held", 32'(ramAddr), 32'h2003f);
        op(4'h6, 18'h00015);
        op(4'h7, 18'h00015);
        check("reserved", 32'(ramAddr), 32'h2003f);
        check("wrapFlagN", 32'(wrapFlagN), 32'h0);
        u_bac_host_model.select(1'b0, 1'b1);
        op(CNT_READ);
        check("addrOe", 32'(addrOe), 32'h1);
        check("counter", 32'(addrOut), 32'h2003f);
        check("dqHighZ", 32'(dqHighZ), 32'h1);
        op(INC);
        check("rewind", 32'(ramAddr), 32'h2003e);
        check("addrOe", 32'(addrOe), 32'h0);
        u_bac_host_model.select(1'b1, 1'b0);
        op(MASK_READ);
        check("mask", 32'(addrOut), 32'h3f);
    endtask

    task automatic tRelease();
        logic [3:0] codes [4] = '{CNT_CLEAR, CNT_LOAD, MASK_SET, MASK_LOAD};
        for (int k = 0; k < 4; k++) begin
            op(MASK_LOAD, 18'h3f);
            op(CNT_LOAD, 18'h2003e);
            op(INC);
            check("wrapFlagN", 32'(wrapFlagN), 32'h0);
            op(codes[k], 18'h3f);
            check("wrapFlagN", 32'(wrapFlagN), 32'h1);
            if (k == 0)
                check("cleared", 32'(ramAddr), 32'h20000);
            if (k == 2) begin
                op(MASK_READ);
                check("mask", 32'(addrOut), 32'(ONES));
            end
        end
    endtask

    task automatic tByTwo();
        op(MASK_LOAD, 18'h3e);
        op(CNT_LOAD, 18'h20031);
        for (int v = 'h33; v <= 'h3f; v += 2) begin
            op(INC);
            check("step", 32'(ramAddr), 32'h20000 + 32'(v));
            check("wrapFlagN", 32'(wrapFlagN), (v == 'h3f) ? 32'h0 : 32'h1);
        end
        op(CNT_CLEAR);
        check("cleared", 32'(ramAddr), 32'h20001);
        repeat (31) op(INC);
        check("top", 32'(ramAddr), 32'h2003f);
        op(INC);
        check("rewind", 32'(ramAddr), 32'h20001);
    endtask

    task automatic tMaster();
        op(CNT_LOAD, 18'h12345);
        #3 globalInitN = 1'b0;
        #1 check("ramAddr", 32'(ramAddr), 32'h0);
        @(posedge clk);
        #1;
        op(INC);
        check("ramAddr", 32'(ramAddr), 32'h0);
        check("wrapFlagN", 32'(wrapFlagN), 32'h1);
        globalInitN = 1'b1;
        op(MASK_READ);
        check("mask", 32'(addrOut), 32'(ONES));
    endtask

    initial begin
        sys_rst     = 1'b1;
        globalInitN = 1'b1;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        tReset();
        tWrap();
        tHold();
        tRelease();
        tByTwo();
        tMaster();
        give_verdict();
    end

    // Cuts a hang short
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end
endmodule // test_bac_top
